// [core/cpm_pkg.sv]
// shared types and constants of the converter protection manager
`default_nettype none
package cpm_pkg;
  // restart interval after a non-latching trip
  localparam int HICCUP_TIME_MS = 130;
  localparam int CLK_FREQ_MHZ = 200;
  localparam int HICCUP_CYCLES = HICCUP_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam logic [6:0] STATUS_RESET = 7'h7f;

  // one bit per fault-class or error-class protection
  typedef struct packed {
    logic ramp_track;
    logic overheat;
    logic overcurrent;
    logic undervoltage;
    logic overvoltage;
  } cpm_fault_t;

  // active-low status word read by the power manager
  typedef struct packed {
    logic temp_warning_status_bit;
    logic output_in_window_status;
    logic overcurrent_status_bit;
    logic undervoltage_status_bit;
    logic overheat_fault_status_bit;
    logic ramp_tracking_status_bit;
    logic overvoltage_status_bit;
  } cpm_status_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_RUN = 3'h1,
    S_OFF = 3'h3,
    S_HICCUP = 3'h2,
    S_LATCH = 3'h6
  } cpm_state_t;
endpackage
`default_nettype wire

// [core/cpm_protection_manager.sv]
// protection, status and restart control of a point-of-load converter
// How it works
// - above 120C: temp warning bit goes 0
// - below 117C: temp warning bit returns 1
// - warnings never shut the output down
// - temp warning forwarded only when enabled
// - power-good low outside 110% / 90-95% window
// - window checked in steady state only
// - power-good warning clears bit, optional message
// - every fault turns the converter off
// - overcurrent/overvoltage armed above pre-bias only
// - current limit below UV: fast off
// - steady-state undervoltage without overcurrent: ramp down
// - over 120C while powered: sequenced ramp down
// - non-latching overheat restarts below 110C
// - tracking armed only during ramp-up
// - tracking error over 250mV: fast off
// - tracking check off when enable cleared
// - overvoltage: high side off, low side clamps
// - overvoltage trip 110-130%, never below 1.0V
// - faults may propagate to other converters
// - non-latching trips other than overheat retry every 130ms
// - latching trips stay off until cleared
// - propagated fault pulls shared group line low
`default_nettype none
module cpm_protection_manager
  import cpm_pkg::*;
#(
  parameter int HICCUP_LEN = HICCUP_CYCLES,
  parameter int CNT_W = $clog2(HICCUP_CYCLES + 1)
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // comparator results from the analogue front end
  input wire logic TEMP_ABOVE_120,
  input wire logic TEMP_BELOW_117,
  input wire logic TEMP_BELOW_110,
  input wire logic VOUT_ABOVE_PG_HIGH,
  input wire logic VOUT_BELOW_PG_LOW90,
  input wire logic VOUT_BELOW_PG_LOW95,
  input wire logic VOUT_BELOW_UV,
  input wire logic VOUT_ABOVE_OV_LEVEL,
  input wire logic VOUT_ABOVE_1V0,
  input wire logic VOUT_ABOVE_PREBIAS,
  input wire logic CURRENT_LIMIT_ACTIVE,
  input wire logic TRACK_DIFF_OVER_250MV,
  // converter sequencing state
  input wire logic TURN_ON,
  input wire logic RAMPING_UP,
  input wire logic STEADY_STATE,
  input wire logic OUTPUT_AT_ZERO,
  // configuration written by the power manager
  input wire logic PG_LOW_SEL_95,
  input wire logic [1:0] OV_LEVEL_SEL,
  input wire logic TRACK_EN,
  input wire logic TEMP_COMP_EN,
  input wire cpm_fault_t LATCH_CFG,
  input wire cpm_fault_t PROP_CFG,
  input wire logic TEMP_WARN_MSG_EN,
  input wire logic PG_MSG_EN,
  input wire logic STATUS_CLEAR,
  // power-good open-collector pin
  input wire logic PG_IN,
  output logic PG_OUT,
  output logic PG_OE_N,
  // shared group status line, open collector
  input wire logic OK_IN,
  output logic OK_OUT,
  output logic OK_OE_N,
  // power stage control
  output logic CONV_ENABLE,
  output logic RAMP_DOWN_REQ,
  output logic HS_FAST_OFF,
  output logic LS_CLAMP,
  output logic [1:0] OV_LEVEL_OUT,
  output logic TEMP_COMP_OUT,
  // status to the power manager
  output var cpm_status_t STATUS,
  output logic TEMP_WARN_MSG,
  output logic PG_MSG
);

  cpm_state_t state_reg;
  cpm_fault_t cause_reg;
  cpm_fault_t evt;
  logic [CNT_W-1:0] cnt_reg;
  logic ok_ext;
  logic pg_ext;
  logic pg_bad;
  logic any_evt;
  logic pg_low;
  logic armed;

  function automatic logic cfg_hit(input cpm_fault_t a, input cpm_fault_t b);
    cfg_hit = |(a & b);
  endfunction

  // a low seen while we do not drive belongs to somebody else
  assign ok_ext = !OK_IN && OK_OE_N;
  assign pg_ext = !PG_IN && PG_OE_N;
  assign pg_low = PG_LOW_SEL_95 ? VOUT_BELOW_PG_LOW95 : VOUT_BELOW_PG_LOW90;
  assign pg_bad = !STEADY_STATE || VOUT_ABOVE_PG_HIGH || pg_low;
  assign armed = VOUT_ABOVE_PREBIAS;

  always_comb
  begin
    evt.overcurrent = armed && CURRENT_LIMIT_ACTIVE && VOUT_BELOW_UV;
    evt.undervoltage = STEADY_STATE && VOUT_BELOW_UV && !CURRENT_LIMIT_ACTIVE;
    evt.overheat = TEMP_ABOVE_120;
    evt.ramp_track = RAMPING_UP && TRACK_EN && TRACK_DIFF_OVER_250MV;
    // trip level is the larger of the percentage and 1.0V
    evt.overvoltage = armed && VOUT_ABOVE_OV_LEVEL && VOUT_ABOVE_1V0;
  end

  // warnings are deliberately absent here, so they cannot stop the output
  assign any_evt = |evt;

  // config pass-through to the analogue side
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      OV_LEVEL_OUT <= 2'h2;
      TEMP_COMP_OUT <= 1'h1;
    end
    else
    begin
      OV_LEVEL_OUT <= OV_LEVEL_SEL;
      TEMP_COMP_OUT <= TEMP_COMP_EN;
    end
  end

  // status bits in one process so the word has a single driver; set wins over a clear
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      STATUS <= STATUS_RESET;
    else
    begin
      if (TEMP_ABOVE_120)
        STATUS.temp_warning_status_bit <= 1'h0;
      else if (TEMP_BELOW_117)
        STATUS.temp_warning_status_bit <= 1'h1;
      STATUS.output_in_window_status <= !(pg_bad || pg_ext);
      if (evt.overcurrent)
        STATUS.overcurrent_status_bit <= 1'h0;
      else if (STATUS_CLEAR)
        STATUS.overcurrent_status_bit <= 1'h1;
      if (evt.undervoltage)
        STATUS.undervoltage_status_bit <= 1'h0;
      else if (STATUS_CLEAR)
        STATUS.undervoltage_status_bit <= 1'h1;
      if (evt.overheat)
        STATUS.overheat_fault_status_bit <= 1'h0;
      else if (STATUS_CLEAR)
        STATUS.overheat_fault_status_bit <= 1'h1;
      if (evt.ramp_track)
        STATUS.ramp_tracking_status_bit <= 1'h0;
      else if (STATUS_CLEAR)
        STATUS.ramp_tracking_status_bit <= 1'h1;
      if (evt.overvoltage)
        STATUS.overvoltage_status_bit <= 1'h0;
      else if (STATUS_CLEAR)
        STATUS.overvoltage_status_bit <= 1'h1;
    end
  end

  // messages to the power manager; the power-good pin is only pulled low, never driven high
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      TEMP_WARN_MSG <= 1'h0;
      PG_MSG <= 1'h0;
      PG_OUT <= 1'h0;
      PG_OE_N <= 1'h0;
    end
    else
    begin
      TEMP_WARN_MSG <= TEMP_WARN_MSG_EN && !STATUS.temp_warning_status_bit;
      PG_MSG <= PG_MSG_EN && !STATUS.output_in_window_status;
      PG_OE_N <= !pg_bad;
    end
  end

  // turn-off sequencing and restart
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state_reg <= S_IDLE;
      cause_reg <= '0;
      cnt_reg <= '0;
    end
    else if (!TURN_ON && state_reg != S_OFF)
    begin
      state_reg <= S_IDLE;
      cause_reg <= '0;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (TURN_ON)
            state_reg <= S_RUN;
        end
        S_RUN:
        begin
          if (any_evt || ok_ext)
          begin
            state_reg <= S_OFF;
            cause_reg <= evt;
          end
        end
        S_OFF:
        begin
          cause_reg <= cause_reg | evt;
          if (OUTPUT_AT_ZERO)
          begin
            cnt_reg <= CNT_W'(HICCUP_LEN - 1);
            if (cfg_hit(cause_reg, LATCH_CFG))
              state_reg <= S_LATCH;
            else
              state_reg <= S_HICCUP;
          end
        end
        S_HICCUP:
        begin
          if (cnt_reg != '0)
            cnt_reg <= cnt_reg - 1'b1;
          if (cause_reg.overheat)
          begin
            if (TEMP_BELOW_110)
              state_reg <= S_RUN;
          end
          else if (cnt_reg == '0)
            state_reg <= S_RUN;
        end
        S_LATCH:
        begin
          if (STATUS_CLEAR && !cfg_hit(cause_reg, evt))
          begin
            state_reg <= S_HICCUP;
            cause_reg <= '0;
          end
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // power stage commands, held until the next run or turn-off by command
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      CONV_ENABLE <= 1'h0;
      RAMP_DOWN_REQ <= 1'h0;
      HS_FAST_OFF <= 1'h0;
      LS_CLAMP <= 1'h0;
      OK_OUT <= 1'h0;
      OK_OE_N <= 1'h1;
    end
    else if (state_reg == S_RUN && (any_evt || ok_ext))
    begin
      CONV_ENABLE <= 1'h0;
      HS_FAST_OFF <= evt.overcurrent || evt.ramp_track || evt.overvoltage;
      LS_CLAMP <= evt.overvoltage;
      // a group shutdown follows the regular sequenced path
      RAMP_DOWN_REQ <= !(evt.overcurrent || evt.ramp_track || evt.overvoltage);
      OK_OE_N <= !cfg_hit(evt, PROP_CFG);
    end
    else if (state_reg == S_RUN || state_reg == S_IDLE)
    begin
      // follows the command at once, so dropping it stops the stage at the same edge
      CONV_ENABLE <= TURN_ON;
      RAMP_DOWN_REQ <= 1'h0;
      HS_FAST_OFF <= 1'h0;
      LS_CLAMP <= 1'h0;
      OK_OE_N <= 1'h1;
    end
    else
    begin
      CONV_ENABLE <= state_reg == S_HICCUP &&
        (cause_reg.overheat ? TEMP_BELOW_110 : cnt_reg == '0);
      OK_OE_N <= !cfg_hit(cause_reg, PROP_CFG);
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  temp_warn_set_a: assert property (TEMP_ABOVE_120 |=> !STATUS.temp_warning_status_bit)
    else $error("temp warning bit not lowered");
  temp_warn_rel_a: assert property (TEMP_BELOW_117 && !TEMP_ABOVE_120
    |=> STATUS.temp_warning_status_bit)
    else $error("temp warning bit not restored");
  warn_keeps_on_a: assert property (state_reg == S_RUN && TURN_ON && !any_evt && !ok_ext
    |=> CONV_ENABLE && state_reg == S_RUN)
    else $error("warning turned converter off");
  warn_msg_gate_a: assert property (!TEMP_WARN_MSG_EN |=> !TEMP_WARN_MSG)
    else $error("temp message sent while disabled");
  pg_transition_a: assert property (!STEADY_STATE |=> !PG_OE_N && !STATUS.output_in_window_status)
    else $error("power good released outside steady state");
  fault_off_a: assert property (state_reg == S_RUN && TURN_ON && any_evt
    |=> !CONV_ENABLE && state_reg == S_OFF ##1 !CONV_ENABLE)
    else $error("fault did not turn converter off");
  ov_clamp_a: assert property (state_reg == S_RUN && TURN_ON && evt.overvoltage
    |=> LS_CLAMP && HS_FAST_OFF && !STATUS.overvoltage_status_bit)
    else $error("overvoltage clamp missing");
  track_fast_a: assert property (state_reg == S_RUN && TURN_ON && evt.ramp_track
    |=> HS_FAST_OFF && !RAMP_DOWN_REQ && !STATUS.ramp_tracking_status_bit)
    else $error("tracking fault not fast off");
  hiccup_end_a: assert property (state_reg == S_HICCUP && TURN_ON && cnt_reg == '0
    && !cause_reg.overheat |=> state_reg == S_RUN)
    else $error("retry did not restart");
  latch_hold_a: assert property (state_reg == S_LATCH && TURN_ON && !STATUS_CLEAR
    |=> state_reg == S_LATCH && !CONV_ENABLE)
    else $error("latched fault left without clear");

  ok_pull_c: cover property (state_reg == S_RUN && any_evt ##1 !OK_OE_N);
  hiccup_c: cover property (state_reg == S_HICCUP ##1 state_reg == S_RUN);
  latch_c: cover property (state_reg == S_LATCH ##[1:20] state_reg == S_HICCUP);
  pg_ext_c: cover property (pg_ext && STEADY_STATE);

endmodule
`default_nettype wire

// [core/cpm_unused_guard.sv]
// intentionally empty companion file
`default_nettype none
`default_nettype wire

// [testbench/cpm_power_manager_model.sv]
// power manager side: open-collector wire levels and the settings it keeps
`default_nettype none
module cpm_power_manager_model (
  // open-collector lines
  input wire logic pg_oe_n,
  input wire logic ok_oe_n,
  input wire logic pg_ext_pull,
  input wire logic ok_ext_pull,
  output logic pg_wire,
  output logic ok_wire,
  // settings
  input wire logic comp_off_req,
  output logic temp_comp_en
);
  timeunit 1ns;
  timeprecision 100ps;
  // pull-ups hold both lines high unless someone pulls low
  assign pg_wire = pg_oe_n & ~pg_ext_pull;
  assign ok_wire = ok_oe_n & ~ok_ext_pull;
  // compensation stays on unless software turns it off
  assign temp_comp_en = ~comp_off_req;
endmodule
`default_nettype wire

// [testbench/tb_cpm_protection_manager.sv]
// self-checking bench of the converter protection manager
`default_nettype none
module tb_cpm_protection_manager
  import cpm_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK_SYS, RST, TEMP_ABOVE_120, TEMP_BELOW_117, TEMP_BELOW_110, VOUT_ABOVE_PG_HIGH;
  logic VOUT_BELOW_PG_LOW90, VOUT_BELOW_PG_LOW95, VOUT_BELOW_UV, VOUT_ABOVE_OV_LEVEL;
  logic VOUT_ABOVE_1V0, VOUT_ABOVE_PREBIAS, CURRENT_LIMIT_ACTIVE, TRACK_DIFF_OVER_250MV;
  logic TURN_ON, RAMPING_UP, STEADY_STATE, OUTPUT_AT_ZERO, PG_LOW_SEL_95, TRACK_EN;
  logic TEMP_COMP_EN, TEMP_WARN_MSG_EN, PG_MSG_EN, STATUS_CLEAR, PG_IN, PG_OUT, PG_OE_N;
  logic OK_IN, OK_OUT, OK_OE_N, CONV_ENABLE, RAMP_DOWN_REQ, HS_FAST_OFF, LS_CLAMP;
  logic TEMP_COMP_OUT, TEMP_WARN_MSG, PG_MSG;
  logic [1:0] OV_LEVEL_SEL, OV_LEVEL_OUT;
  cpm_fault_t LATCH_CFG, PROP_CFG;
  cpm_status_t STATUS;
  int n_errors = 0;
  int samples_checked = 0;
  logic pg_pull = 1'h0;
  logic comp_off = 1'h0;
  logic ok_pull = 1'h0;
  // {t120, t117, low90, low95, sel95, high, steady}, {warn bit, pg release}
  logic [8:0] rows [9] = '{9'h100, 9'h000, 9'h082, 9'h087, 9'h0a7, 9'h0b6, 9'h08e, 9'h0c6,
    9'h082};

  // short restart interval keeps the run brief
  cpm_protection_manager #(.HICCUP_LEN(16)) dut_u (
    .CLK_SYS(CLK_SYS), .RST(RST), .TEMP_ABOVE_120(TEMP_ABOVE_120),
    .TEMP_BELOW_117(TEMP_BELOW_117), .TEMP_BELOW_110(TEMP_BELOW_110),
    .VOUT_ABOVE_PG_HIGH(VOUT_ABOVE_PG_HIGH), .VOUT_BELOW_PG_LOW90(VOUT_BELOW_PG_LOW90),
    .VOUT_BELOW_PG_LOW95(VOUT_BELOW_PG_LOW95), .VOUT_BELOW_UV(VOUT_BELOW_UV),
    .VOUT_ABOVE_OV_LEVEL(VOUT_ABOVE_OV_LEVEL), .VOUT_ABOVE_1V0(VOUT_ABOVE_1V0),
    .VOUT_ABOVE_PREBIAS(VOUT_ABOVE_PREBIAS), .CURRENT_LIMIT_ACTIVE(CURRENT_LIMIT_ACTIVE),
    .TRACK_DIFF_OVER_250MV(TRACK_DIFF_OVER_250MV), .TURN_ON(TURN_ON),
    .RAMPING_UP(RAMPING_UP), .STEADY_STATE(STEADY_STATE), .OUTPUT_AT_ZERO(OUTPUT_AT_ZERO),
    .PG_LOW_SEL_95(PG_LOW_SEL_95), .OV_LEVEL_SEL(OV_LEVEL_SEL), .TRACK_EN(TRACK_EN),
    .TEMP_COMP_EN(TEMP_COMP_EN), .LATCH_CFG(LATCH_CFG), .PROP_CFG(PROP_CFG),
    .TEMP_WARN_MSG_EN(TEMP_WARN_MSG_EN), .PG_MSG_EN(PG_MSG_EN), .STATUS_CLEAR(STATUS_CLEAR),
    .PG_IN(PG_IN), .PG_OUT(PG_OUT), .PG_OE_N(PG_OE_N), .OK_IN(OK_IN), .OK_OUT(OK_OUT),
    .OK_OE_N(OK_OE_N), .CONV_ENABLE(CONV_ENABLE), .RAMP_DOWN_REQ(RAMP_DOWN_REQ),
    .HS_FAST_OFF(HS_FAST_OFF), .LS_CLAMP(LS_CLAMP), .OV_LEVEL_OUT(OV_LEVEL_OUT),
    .TEMP_COMP_OUT(TEMP_COMP_OUT), .STATUS(STATUS), .TEMP_WARN_MSG(TEMP_WARN_MSG),
    .PG_MSG(PG_MSG)
  );

  cpm_power_manager_model pm_u (
    .pg_oe_n(PG_OE_N),
    .ok_oe_n(OK_OE_N),
    .pg_ext_pull(pg_pull),
    .ok_ext_pull(ok_pull),
    .pg_wire(PG_IN),
    .ok_wire(OK_IN),
    .comp_off_req(comp_off),
    .temp_comp_en(TEMP_COMP_EN)
  );

  initial
  begin
    CLK_SYS = 1'h0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bounded wait for the converter to run again
  task automatic wait_run(input int lim);
    int k;
    k = 0;
    while (CONV_ENABLE !== 1'h1 && k < lim)
    begin
      tick(1);
      k++;
    end
    chk_bit("restart", 1'h1, CONV_ENABLE);
    if (CONV_ENABLE !== 1'h1)
      tally_and_finish();
  endtask

  task automatic go_run(input int lim);
    STATUS_CLEAR = 1'h1;
    TURN_ON = 1'h1;
    tick(1);
    STATUS_CLEAR = 1'h0;
    wait_run(lim);
  endtask

  // output reaches zero: off phase ends
  task automatic at_zero();
    OUTPUT_AT_ZERO = 1'h1;
    tick(1);
    OUTPUT_AT_ZERO = 1'h0;
  endtask

  initial
  begin
    {TEMP_ABOVE_120, TEMP_BELOW_117, TEMP_BELOW_110, VOUT_ABOVE_PG_HIGH, VOUT_BELOW_PG_LOW90,
      VOUT_BELOW_PG_LOW95, VOUT_BELOW_UV, VOUT_ABOVE_OV_LEVEL, VOUT_ABOVE_1V0,
      VOUT_ABOVE_PREBIAS, CURRENT_LIMIT_ACTIVE, TRACK_DIFF_OVER_250MV, TURN_ON, RAMPING_UP,
      STEADY_STATE, OUTPUT_AT_ZERO, PG_LOW_SEL_95, OV_LEVEL_SEL, TRACK_EN, LATCH_CFG,
      PROP_CFG, TEMP_WARN_MSG_EN, PG_MSG_EN, STATUS_CLEAR} = '0;
    RST = 1'h1;
    tick(2);
    RST = 1'h0;
    chk_word("status", 8'h7f, {1'h0, STATUS});
    chk_bit("pg release", 1'h0, PG_OE_N);
    chk_bit("pg drive", 1'h0, PG_OUT);
    chk_bit("group release", 1'h1, OK_OE_N);
    chk_bit("group drive", 1'h0, OK_OUT);
    chk_bit("run", 1'h0, CONV_ENABLE);
    chk_word("ov level", 8'h02, {6'h0, OV_LEVEL_OUT});
    comp_off = 1'h1;
    OV_LEVEL_SEL = 2'h1;
    TEMP_WARN_MSG_EN = 1'h1;
    PG_MSG_EN = 1'h1;
    tick(2);
    chk_bit("temp comp", 1'h0, TEMP_COMP_OUT);
    chk_word("ov level", 8'h01, {6'h0, OV_LEVEL_OUT});
    foreach (rows[i])
    begin
      {TEMP_ABOVE_120, TEMP_BELOW_117, VOUT_BELOW_PG_LOW90, VOUT_BELOW_PG_LOW95, PG_LOW_SEL_95,
        VOUT_ABOVE_PG_HIGH, STEADY_STATE} = rows[i][8:2];
      tick(3);
      chk_bit("temp warn", rows[i][1], STATUS.temp_warning_status_bit);
      chk_bit("temp msg", ~rows[i][1], TEMP_WARN_MSG);
      chk_bit("pg release", rows[i][0], PG_OE_N);
    end
    // warning without reporting enabled
    TEMP_WARN_MSG_EN = 1'h0;
    {TEMP_ABOVE_120, TEMP_BELOW_117} = 2'h2;
    tick(3);
    chk_bit("temp msg off", 1'h0, TEMP_WARN_MSG);
    {TEMP_ABOVE_120, TEMP_BELOW_117, STEADY_STATE, pg_pull} = 4'h7;
    tick(3);
    chk_bit("pg bit", 1'h0, STATUS.output_in_window_status);
    chk_bit("pg msg", 1'h1, PG_MSG);
    pg_pull = 1'h0;
    tick(3);
    chk_bit("pg bit", 1'h1, STATUS.output_in_window_status);
    STEADY_STATE = 1'h0;
    go_run(5);
    chk_word("status", 8'h5f, {1'h0, STATUS} & 8'h5f);
    // overcurrent below pre-bias is ignored, above it trips fast
    PROP_CFG = 5'h04;
    {CURRENT_LIMIT_ACTIVE, VOUT_BELOW_UV} = 2'h3;
    tick(2);
    chk_bit("run", 1'h1, CONV_ENABLE);
    VOUT_ABOVE_PREBIAS = 1'h1;
    tick(1);
    chk_bit("run", 1'h0, CONV_ENABLE);
    chk_bit("fast off", 1'h1, HS_FAST_OFF);
    chk_bit("oc bit", 1'h0, STATUS.overcurrent_status_bit);
    chk_bit("group pull", 1'h0, OK_OE_N);
    {CURRENT_LIMIT_ACTIVE, VOUT_BELOW_UV} = 2'h0;
    at_zero();
    tick(12);
    chk_bit("hiccup", 1'h0, CONV_ENABLE);
    wait_run(10);
    chk_bit("oc held", 1'h0, STATUS.overcurrent_status_bit);
    // overvoltage: floor gates the trip, then clamp and latch
    PROP_CFG = 5'h00;
    LATCH_CFG = 5'h01;
    VOUT_ABOVE_OV_LEVEL = 1'h1;
    tick(2);
    chk_bit("run", 1'h1, CONV_ENABLE);
    VOUT_ABOVE_1V0 = 1'h1;
    tick(1);
    chk_bit("fast off", 1'h1, HS_FAST_OFF);
    chk_bit("clamp", 1'h1, LS_CLAMP);
    chk_bit("ov bit", 1'h0, STATUS.overvoltage_status_bit);
    VOUT_ABOVE_OV_LEVEL = 1'h0;
    at_zero();
    tick(40);
    chk_bit("latched", 1'h0, CONV_ENABLE);
    go_run(25);
    LATCH_CFG = 5'h00;
    // overheat: sequenced off, restart once cool
    {TEMP_ABOVE_120, TEMP_BELOW_117} = 2'h2;
    tick(1);
    chk_bit("ramp down", 1'h1, RAMP_DOWN_REQ);
    chk_bit("fast off", 1'h0, HS_FAST_OFF);
    chk_bit("ot bit", 1'h0, STATUS.overheat_fault_status_bit);
    TEMP_ABOVE_120 = 1'h0;
    at_zero();
    tick(30);
    chk_bit("hot wait", 1'h0, CONV_ENABLE);
    {TEMP_BELOW_110, TEMP_BELOW_117} = 2'h3;
    wait_run(20);
    // tracking and power-good warning while running
    go_run(5);
    {STEADY_STATE, VOUT_ABOVE_PG_HIGH, TRACK_EN, TRACK_DIFF_OVER_250MV} = 4'hf;
    tick(2);
    chk_bit("run", 1'h1, CONV_ENABLE);
    {STEADY_STATE, VOUT_ABOVE_PG_HIGH, TRACK_EN, RAMPING_UP} = 4'h1;
    tick(2);
    chk_bit("run", 1'h1, CONV_ENABLE);
    TRACK_EN = 1'h1;
    tick(1);
    chk_bit("fast off", 1'h1, HS_FAST_OFF);
    chk_bit("tr bit", 1'h0, STATUS.ramp_tracking_status_bit);
    // reset in mid-run while tripped
    RST = 1'h1;
    {RAMPING_UP, TRACK_DIFF_OVER_250MV} = 2'h0;
    tick(2);
    RST = 1'h0;
    chk_word("status", 8'h7f, {1'h0, STATUS});
    chk_bit("fast off", 1'h0, HS_FAST_OFF);
    chk_bit("run", 1'h0, CONV_ENABLE);
    // a low on the group line from elsewhere turns this converter off the regular way
    go_run(5);
    ok_pull = 1'h1;
    tick(1);
    chk_bit("run", 1'h0, CONV_ENABLE);
    chk_bit("ramp down", 1'h1, RAMP_DOWN_REQ);
    chk_bit("group pull", 1'h1, OK_OE_N);
    tally_and_finish();
  end
endmodule
`default_nettype wire
